/* dv/adc_seq_model.sv */
`timescale 1ns/1ps
module adc_seq_model
  import power_calc_pkg::*;
(
  // Clock and request
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic [31:0] data_i,
  // Samples to the engine
  output adc_sample_t sample_o
);
  // Shunt then bus, data toggles when idle
  always @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_o <= '0;
    end else begin
      sample_o.shunt_valid <= go_i;
      sample_o.bus_valid <= sample_o.shunt_valid;
      sample_o.shunt <= go_i ? data_i[31:16] : ~sample_o.shunt;
      sample_o.bus <= sample_o.shunt_valid ? data_i[15:0] : ~sample_o.bus;
    end
  end
endmodule

/* dv/calc_engine_sva.sv */
`timescale 1ns/1ps
module calc_engine_sva
  import power_calc_pkg::*;
#(parameter int AVG_LIMIT = AVG_MAX) (
  // Watched ports
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [CAL_W-1:0] shunt_cal_i,
  input wire logic [AVG_CNT_W-1:0] avg_count_i,
  input wire logic restart_i,
  input wire adc_sample_t sample_i,
  input wire calc_result_t result_o,
  input wire logic result_load_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  rst_val_a: assert property ($rose(rst_n_i) |-> result_o == '0 && !result_load_o)
    else $error("outputs not clear");
  load_pulse_a: assert property (result_load_o |=> !result_load_o)
    else $error("load too long");
  out_hold_a: assert property (!result_load_o |-> $stable(result_o))
    else $error("result moved");
  load_cause_a: assert property (result_load_o |-> $past(sample_i.bus_valid, 5))
    else $error("load without pair");
  pair_load_a: assert property (sample_i.shunt_valid ##1
    (sample_i.bus_valid && avg_count_i == AVG_ONE) |-> ##5 result_load_o) else $error("no load");
  zero_pwr_a: assert property (result_load_o && avg_count_i == AVG_ONE &&
    shunt_cal_i == CAL_ZERO |-> result_o.power == '0) else $error("power not zero");
  zero_cur_a: assert property (result_load_o && avg_count_i == AVG_ONE &&
    shunt_cal_i == CAL_ZERO |-> result_o.current == '0) else $error("current not zero");
  restart_drop_a: assert property (restart_i |=> !result_load_o)
    else $error("load after restart");
  cur_val_a: assert property (result_load_o && avg_count_i == AVG_ONE |->
    result_o.current == CUR_W'((32'($past(sample_i.shunt, 6)) * 32'(shunt_cal_i)) >> CUR_SHIFT))
    else $error("current wrong");
  cover property (result_load_o && avg_count_i > AVG_ONE);
  cover property (result_load_o && shunt_cal_i == CAL_ZERO);
  cover property (result_load_o && avg_count_i == 11'h400);
  cover property (restart_i);
endmodule
bind current_power_calc_engine calc_engine_sva #(.AVG_LIMIT(AVG_LIMIT)) calc_engine_sva_i (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .shunt_cal_i(shunt_cal_i),
  .avg_count_i(avg_count_i), .restart_i(restart_i), .sample_i(sample_i),
  .result_o(result_o), .result_load_o(result_load_o));

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import power_calc_pkg::*;
  logic sys_clk_i = 0, rst_n_i = 0, go = 0, restart = 0, load;
  logic [31:0] loads;
  logic [CAL_W-1:0] cal = '0;
  logic [AVG_CNT_W-1:0] avg = '0;
  logic [31:0] seed = 32'h3b7ad82d, data = '0;
  adc_sample_t smp;
  calc_result_t res;
  int error_cnt = 0, compares = 0, n;
  longint prev = 0, cs, ps, cur;
  int avgs[8] = '{1, 1, 4, 0, 3, 7, 1024, 2047};
  always #12.5 sys_clk_i = ~sys_clk_i;
  adc_seq_model adc_seq_model_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .go_i(go),
    .data_i(data), .sample_o(smp));
  current_power_calc_engine current_power_calc_engine_i (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .shunt_cal_i(cal), .avg_count_i(avg), .restart_i(restart),
    .sample_i(smp), .result_o(res), .result_load_o(load));
  function logic [31:0] rnd(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task pair(input logic last);
    @(negedge sys_clk_i);
    seed = rnd(seed);
    data <= seed;
    go <= 1'b1;
    @(negedge sys_clk_i);
    go <= 1'b0;
    cur = (longint'($signed(seed[31:16])) * longint'(cal)) >>> CUR_SHIFT;
    ps += (cal == 0) ? 0 : ((prev < 0 ? -prev : prev) * longint'(seed[15:0])) >>> PWR_SHIFT;
    cs += cur;
    prev = cur;
    loads = '0;
    repeat (8) begin
      @(posedge sys_clk_i);
      #1 loads = loads + 32'(load);
    end
    cmp("loads", 32'(last), loads);
    if (last) begin
      cmp("current", 32'(cs / n), 32'(res.current));
      cmp("power", 32'(ps / n), 32'(res.power));
    end
  endtask
  initial begin
    repeat (20) @(negedge sys_clk_i);
    rst_n_i = 1;
    foreach (avgs[i]) begin
      @(negedge sys_clk_i);
      seed = rnd(seed);
      cal <= (i == 1) ? '0 : CAL_W'(seed[10:0]);
      avg <= AVG_CNT_W'(avgs[i]);
      n = (avgs[i] == 0) ? 1 : ((avgs[i] > AVG_MAX) ? AVG_MAX : avgs[i]);
      cs = 0;
      ps = 0;
      if (i == 2) begin
        pair(1'b0);
        @(negedge sys_clk_i);
        restart <= 1'b1;
        @(negedge sys_clk_i);
        restart <= 1'b0;
        cs = 0;
        ps = 0;
      end
      for (int k = 0; k < n; k++) begin
        pair(k == n - 1);
      end
    end
    stop_test();
  end
  initial begin
    #750000;
    error_cnt++;
    stop_test();
  end
endmodule

/* rtl/current_power_calc_engine.sv */
// Behaviour
// - New current and power after shunt+bus pair
// - Power uses previous current, latest bus
// - Zero calibration gives zero power
// - Averaging above one goes to accumulator
// - Add each sample until count reached
// - Load averaged results into output registers
// - Arithmetic runs beside ADC, never stalls it
// - Averaging count one up to 1024
// - Outputs hold until next completed result
`timescale 1ns/1ps
module current_power_calc_engine
  import power_calc_pkg::*;
#(
  parameter int AVG_LIMIT = AVG_MAX
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Configuration
  input wire logic [CAL_W-1:0] shunt_cal_i,
  input wire logic [AVG_CNT_W-1:0] avg_count_i,
  input wire logic restart_i,
  // Samples from the sequencer
  input wire adc_sample_t sample_i,
  // Results
  output calc_result_t result_o,
  output logic result_load_o
);

  // Averaging limit must lie in the supported range
  if (AVG_LIMIT < 1 || AVG_LIMIT > AVG_MAX) begin : avg_limit_check
    $error("AVG_LIMIT out of range");
  end
  // Sample counter must be able to hold the limit itself
  if (AVG_LIMIT >= (1 << AVG_CNT_W)) begin : avg_width_check
    $error("AVG_LIMIT too wide for counter");
  end

  localparam int CUR_ACC_W = CUR_W + AVG_CNT_W;
  localparam int PWR_ACC_W = PWR_W + AVG_CNT_W;
  localparam int CUR_PROD_W = SAMPLE_W + CAL_W + 1;
  localparam int PWR_PROD_W = CUR_W + SAMPLE_W + 1;

  calc_state_t state, next_state;
  logic shunt_seen, next_shunt_seen;
  logic bus_seen, next_bus_seen;
  logic signed [SAMPLE_W-1:0] shunt_hold, next_shunt_hold;
  logic [SAMPLE_W-1:0] bus_hold, next_bus_hold;
  logic signed [CUR_W-1:0] cur_prev, next_cur_prev;
  logic signed [CUR_W-1:0] cur_new, next_cur_new;
  logic [PWR_W-1:0] pwr_new, next_pwr_new;
  logic signed [CUR_ACC_W-1:0] cur_acc, next_cur_acc;
  logic [PWR_ACC_W-1:0] pwr_acc, next_pwr_acc;
  logic [AVG_CNT_W-1:0] sample_cnt, next_sample_cnt;
  calc_result_t result, next_result;
  logic load, next_load;
  logic [AVG_CNT_W-1:0] avg_eff;
  logic signed [CUR_PROD_W-1:0] cur_prod;
  logic signed [PWR_PROD_W-1:0] pwr_prod;
  logic [PWR_PROD_W-1:0] pwr_mag;
  logic pair_take;

  // Clamp averaging count into 1..AVG_LIMIT
  // count range clamp
  always_comb begin
    if (avg_count_i == '0) begin
      avg_eff = AVG_ONE;
    end else if (avg_count_i > AVG_CNT_W'(AVG_LIMIT)) begin
      avg_eff = AVG_CNT_W'(AVG_LIMIT);
    end else begin
      avg_eff = avg_count_i;
    end
  end

  // Products for current and power
  always_comb begin
    cur_prod = CUR_PROD_W'(shunt_hold) * $signed({1'b0, shunt_cal_i});
    pwr_prod = PWR_PROD_W'(cur_prev) * $signed({1'b0, bus_hold});
    pwr_mag = pwr_prod[PWR_PROD_W-1] ? PWR_PROD_W'(-pwr_prod) : PWR_PROD_W'(pwr_prod);
  end

  // Samples are always captured, so the sequencer never waits
  // capture without stall
  always_comb begin
    next_shunt_seen = shunt_seen;
    next_bus_seen = bus_seen;
    next_shunt_hold = shunt_hold;
    next_bus_hold = bus_hold;
    if (pair_take) begin
      next_shunt_seen = 1'b0;
      next_bus_seen = 1'b0;
    end
    if (sample_i.shunt_valid) begin
      next_shunt_hold = sample_i.shunt;
      next_shunt_seen = 1'b1;
    end
    if (sample_i.bus_valid) begin
      next_bus_hold = sample_i.bus;
      next_bus_seen = 1'b1;
    end
    if (restart_i) begin
      next_shunt_seen = 1'b0;
      next_bus_seen = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shunt_seen <= 1'b0;
      bus_seen <= 1'b0;
      shunt_hold <= '0;
      bus_hold <= '0;
    end else begin
      shunt_seen <= next_shunt_seen;
      bus_seen <= next_bus_seen;
      shunt_hold <= next_shunt_hold;
      bus_hold <= next_bus_hold;
    end
  end

  // Pair is taken when the engine is idle and both samples are held
  assign pair_take = (state == ST_WAIT) && shunt_seen && bus_seen;

  // Engine sequencing, accumulation and output load
  always_comb begin
    next_state = state;
    next_cur_prev = cur_prev;
    next_cur_new = cur_new;
    next_pwr_new = pwr_new;
    next_cur_acc = cur_acc;
    next_pwr_acc = pwr_acc;
    next_sample_cnt = sample_cnt;
    next_result = result;
    next_load = 1'b0;
    case (state)
      ST_WAIT: begin
        if (pair_take) begin
          next_state = ST_CURRENT;
        end
      end
      ST_CURRENT: begin
        next_cur_new = CUR_W'(cur_prod >>> CUR_SHIFT);
        next_state = ST_POWER;
      end
      ST_POWER: begin
        if (shunt_cal_i == CAL_ZERO) begin
          next_pwr_new = '0;
        end else begin
          next_pwr_new = PWR_W'(pwr_mag >> PWR_SHIFT);
        end
        next_cur_prev = cur_new;
        next_state = ST_LOAD;
      end
      ST_LOAD: begin
        if (sample_cnt == '0) begin
          next_cur_acc = CUR_ACC_W'(cur_new);
          next_pwr_acc = PWR_ACC_W'(pwr_new);
        end else begin
          next_cur_acc = cur_acc + CUR_ACC_W'(cur_new);
          next_pwr_acc = pwr_acc + PWR_ACC_W'(pwr_new);
        end
        next_sample_cnt = sample_cnt + AVG_ONE;
        next_state = ST_WAIT;
        if (avg_eff == AVG_ONE) begin
          next_result.current = cur_new;
          next_result.power = pwr_new;
          next_sample_cnt = '0;
          next_load = 1'b1;
        end else if (next_sample_cnt >= avg_eff) begin
          next_result.current = CUR_W'(next_cur_acc / $signed({1'b0, avg_eff}));
          next_result.power = PWR_W'(next_pwr_acc / avg_eff);
          next_sample_cnt = '0;
          next_load = 1'b1;
        end
      end
      default: begin
        next_state = ST_WAIT;
      end
    endcase
    if (restart_i) begin
      next_sample_cnt = '0;
      next_state = ST_WAIT;
      next_load = 1'b0;
      next_result = result;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_WAIT;
      cur_prev <= '0;
      cur_new <= '0;
      pwr_new <= '0;
      cur_acc <= '0;
      pwr_acc <= '0;
      sample_cnt <= '0;
      result <= '0;
      load <= 1'b0;
    end else begin
      state <= next_state;
      cur_prev <= next_cur_prev;
      cur_new <= next_cur_new;
      pwr_new <= next_pwr_new;
      cur_acc <= next_cur_acc;
      pwr_acc <= next_pwr_acc;
      sample_cnt <= next_sample_cnt;
      result <= next_result;
      load <= next_load;
    end
  end

  assign result_o = result;
  assign result_load_o = load;

endmodule

/* shared/power_calc_pkg.sv */
package power_calc_pkg;

  // Sample and result widths
  localparam int SAMPLE_W = 16;
  localparam int CAL_W = 15;
  localparam int CUR_W = 16;
  localparam int PWR_W = 24;

  // Averaging count limits
  localparam int AVG_MAX = 1024;
  localparam int AVG_CNT_W = 11;

  // Current scaling shift applied to shunt times calibration
  localparam int CUR_SHIFT = 11;
  // Power scaling shift applied to current times bus
  localparam int PWR_SHIFT = 8;

  localparam logic [AVG_CNT_W-1:0] AVG_ONE = 11'h001;
  localparam logic [CAL_W-1:0] CAL_ZERO = 15'h0000;

  // Conversion result from the sequencer
  typedef struct packed {
    logic shunt_valid;
    logic bus_valid;
    logic signed [SAMPLE_W-1:0] shunt;
    logic [SAMPLE_W-1:0] bus;
  } adc_sample_t;

  // Averaged results for the output registers
  typedef struct packed {
    logic signed [CUR_W-1:0] current;
    logic [PWR_W-1:0] power;
  } calc_result_t;

  typedef enum logic [1:0] {
    ST_WAIT,
    ST_CURRENT,
    ST_POWER,
    ST_LOAD
  } calc_state_t;

endpackage
